/* File: rtl/gcpm_defines.vh */
// constants for the gpio / clock-output pin multiplexer
`ifndef GCPM_DEFINES_VH
`define GCPM_DEFINES_VH

// register indices (byte address = index * 4)
`define GCPM_IDX_PIN_SEL        12'h463
`define GCPM_IDX_STRAP_LO       12'h467
`define GCPM_PIN_SEL_RESET      16'h0000

// pin select field layout
`define GCPM_GP_SRC_HI          15
`define GCPM_GP_SRC_LO          13
`define GCPM_GP_SEL_HI          12
`define GCPM_GP_SEL_LO          10
`define GCPM_TXER_BIT           9
`define GCPM_CO_DIV_BIT         8
`define GCPM_CO_SRC_HI          7
`define GCPM_CO_SRC_LO          4
`define GCPM_CO_INV_BIT         3
`define GCPM_CO_SEL_HI          2
`define GCPM_CO_SEL_LO          0

// output select codes
`define GCPM_OSEL_LED           3'h0
`define GCPM_OSEL_CLK           3'h1
`define GCPM_OSEL_IRQ           3'h2
`define GCPM_OSEL_LOW           3'h3
`define GCPM_OSEL_ZERO          3'h6
`define GCPM_OSEL_ONE           3'h7

// clock source codes
`define GCPM_SRC_XTAL           4'h0
`define GCPM_SRC_LINE30         4'h1
`define GCPM_SRC_ADC30          4'h2
`define GCPM_SRC_FREE60         4'h3
`define GCPM_SRC_C7P5           4'h4
`define GCPM_SRC_PLL25          4'h5
`define GCPM_SRC_C2P5           4'h6
`define GCPM_SRC_MODEREF        4'h8
`define GCPM_SRC_RMII_RX        4'h9
`define GCPM_SRC_RMII_TX        4'hA
`define GCPM_SRC_MII_RX         4'hB
`define GCPM_SRC_RGMII_ALN      4'hC
`define GCPM_SRC_RGMII_SHF      4'hD

`define GCPM_STRAP_W            16
`define GCPM_STRAP_PINS         10
`define GCPM_REG_W              16

`endif

/* File: rtl/gcpm_clk_select.v */
// clock source selector shared by both pin paths
`timescale 1ns/1ps
`include "gcpm_defines.vh"

module gcpm_clk_select (
    // source selection
    input  wire [3:0] src_in,
    // link status and the selectable clocks
    input  wire       link_master_in,
    input  wire       crystal_input_clock_in,
    input  wire       free30_in,
    input  wire       rec30_in,
    input  wire       adc30_in,
    input  wire       free60_in,
    input  wire       free7p5_in,
    input  wire       rec7p5_in,
    input  wire       pll25_in,
    input  wire       free2p5_in,
    input  wire       rec2p5_in,
    input  wire       mode_dependent_ref_clock_in,
    input  wire       rmii_rx50_in,
    input  wire       rmii_tx50_in,
    input  wire       mii_rx_clk_in,
    input  wire       rgmii_align_in,
    input  wire       rgmii_shift_in,
    // selected clock
    output reg        clk_sel_out
);

    // pick the source; unused codes give a quiet low level
    always @* begin
        case (src_in)
            `GCPM_SRC_XTAL:      clk_sel_out = crystal_input_clock_in;
            `GCPM_SRC_LINE30:    clk_sel_out = link_master_in ? free30_in : rec30_in;   // [R3]
            `GCPM_SRC_ADC30:     clk_sel_out = adc30_in;
            `GCPM_SRC_FREE60:    clk_sel_out = free60_in;
            `GCPM_SRC_C7P5:      clk_sel_out = link_master_in ? free7p5_in : rec7p5_in; // [R3]
            `GCPM_SRC_PLL25:     clk_sel_out = pll25_in;                                // [R3]
            `GCPM_SRC_C2P5:      clk_sel_out = link_master_in ? free2p5_in : rec2p5_in; // [R3]
            `GCPM_SRC_MODEREF:   clk_sel_out = mode_dependent_ref_clock_in;             // [R6]
            `GCPM_SRC_RMII_RX:   clk_sel_out = rmii_rx50_in;
            `GCPM_SRC_RMII_TX:   clk_sel_out = rmii_tx50_in;
            `GCPM_SRC_MII_RX:    clk_sel_out = mii_rx_clk_in;
            `GCPM_SRC_RGMII_ALN: clk_sel_out = rgmii_align_in;
            `GCPM_SRC_RGMII_SHF: clk_sel_out = rgmii_shift_in;
            default:             clk_sel_out = 1'b0;
        endcase
    end

endmodule

/* File: rtl/gcpm_strap_capture.v */
// strap capture: samples the strap pins once after reset release
`timescale 1ns/1ps
`include "gcpm_defines.vh"

module gcpm_strap_capture (
    // clock, reset, enable
    input  wire                          clock_in,
    input  wire                          nrst_in,
    input  wire                          ce_in,
    // strap pins
    input  wire [`GCPM_STRAP_PINS-1:0]   strap_pins_in,
    // captured vector
    output wire [`GCPM_STRAP_W-1:0]      strap_out
);

    reg [`GCPM_STRAP_PINS-1:0] strap_ff;
    reg                        done_ff;

    // a clocked capture, because an async reset may only load constants
    always @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            strap_ff <= {`GCPM_STRAP_PINS{1'b0}};
            done_ff  <= 1'b0;
        end else if (ce_in && !done_ff) begin
            strap_ff <= strap_pins_in;  // [R11]
            done_ff  <= 1'b1;           // [R11]
        end
    end

    // upper bits are owned elsewhere and read zero
    assign strap_out = {{(`GCPM_STRAP_W-`GCPM_STRAP_PINS){1'b0}}, strap_ff}; // [R10]

endmodule

/* File: rtl/gcpm_pin_mux.v */
// gpio and clock-output pin multiplexer with wishbone register slave
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps
`include "gcpm_defines.vh"

// Contract
// [R1] The gpio pin select field picks LED1, clock, interrupt, low, zero or one; 4 and 5 reserved.
// [R2] The gpio clock source field picks one of seven internal clocks, codes 0 to 6.
// [R3] Sources 1, 4 and 6 are free when link master, recovered when slave; 5 is the PLL reference.
// [R4] The clock-output pin select field uses the same encoding as the gpio pin.
// [R5] The clock-output source field accepts 0 to 6 plus 9 to 13 for MAC-side clocks.
// [R6] Clock-output source 8 is the reference clock, 50 MHz in RMII and 25 MHz otherwise.
// [R7] The divide-enable bit halves the clock-output pin clock.
// [R8] The invert-enable bit inverts the clock-output pin clock.
// [R9] The tx-error bit makes the second LED pin the MII transmit-error input.
// [R10] The strap register reports sampled strap bits, pins mapped to bits 0 to 9.
// [R11] Straps are captured once after reset release and writes to them are ignored.
module gcpm_pin_mux (
    // clock, reset, enable
    input  wire        clock_in,
    input  wire        nrst_in,
    input  wire        ce_in,
    // wishbone slave
    input  wire        wb_cyc_in,
    input  wire        wb_stb_in,
    input  wire        wb_we_in,
    input  wire [13:0] wb_adr_in,
    input  wire [3:0]  wb_sel_in,
    input  wire [31:0] wb_dat_in,
    output reg  [31:0] wb_dat_out,
    output reg         wb_ack_out,
    output reg         wb_err_out,
    // pin function sources
    input  wire        led1_ind_in,
    input  wire        led2_ind_in,
    input  wire        irq_in,
    input  wire        led2_pin_in,
    // clock sources
    input  wire        link_master_in,
    input  wire        crystal_input_clock_in,
    input  wire        free30_in,
    input  wire        rec30_in,
    input  wire        adc30_in,
    input  wire        free60_in,
    input  wire        free7p5_in,
    input  wire        rec7p5_in,
    input  wire        pll25_in,
    input  wire        free2p5_in,
    input  wire        rec2p5_in,
    input  wire        mode_dependent_ref_clock_in,
    input  wire        rmii_rx50_in,
    input  wire        rmii_tx50_in,
    input  wire        mii_rx_clk_in,
    input  wire        rgmii_align_in,
    input  wire        rgmii_shift_in,
    // strap pins: rx_d3, rx_d2, rx_d1, rx_d0, clkout, rx_ctrl, rx_er, led2, led0, gpio
    input  wire [9:0]  strap_pins_in,
    // pin outputs
    output reg         gpio_pin_out,
    output reg         clkout_pin_out,
    output reg         led2_drive_en_out,
    output reg         led2_led_out,
    output reg         tx_error_out
);

    reg  [15:0] pin_sel_ff;
    reg  [15:0] nxt_pin_sel;
    reg         div_ff;
    reg         nxt_gpio;
    reg         nxt_clkout;
    reg  [31:0] nxt_rdata;
    reg         nxt_ack;
    reg         nxt_err;
    wire        gp_clk;
    wire        co_clk;
    wire        co_shaped;
    wire [15:0] strap_vec;
    wire        wb_req;
    wire        hit_sel;
    wire        hit_strap;
    wire [2:0]  gp_sel;
    wire [2:0]  co_sel;
    wire [3:0]  co_src;

    // output select decoding shared by both pins
    function pin_mux_f;
        input [2:0] sel;
        input       led;
        input       clk;
        input       irq;
        begin
            case (sel)
                `GCPM_OSEL_LED:  pin_mux_f = led;
                `GCPM_OSEL_CLK:  pin_mux_f = clk;
                `GCPM_OSEL_IRQ:  pin_mux_f = irq;
                `GCPM_OSEL_LOW:  pin_mux_f = 1'b0;
                `GCPM_OSEL_ZERO: pin_mux_f = 1'b0;
                `GCPM_OSEL_ONE:  pin_mux_f = 1'b1;
                default:         pin_mux_f = 1'b0; // reserved codes hold low
            endcase
        end
    endfunction

    // field extraction
    assign gp_sel = pin_sel_ff[`GCPM_GP_SEL_HI:`GCPM_GP_SEL_LO];
    assign co_sel = pin_sel_ff[`GCPM_CO_SEL_HI:`GCPM_CO_SEL_LO];
    assign co_src = pin_sel_ff[`GCPM_CO_SRC_HI:`GCPM_CO_SRC_LO];

    // gpio clock: three-bit field, top bit of selector held zero
    gcpm_clk_select u_gp_clk (
        .src_in                      ({1'b0, pin_sel_ff[`GCPM_GP_SRC_HI:`GCPM_GP_SRC_LO]}),
        .link_master_in              (link_master_in),
        .crystal_input_clock_in      (crystal_input_clock_in),
        .free30_in                   (free30_in),
        .rec30_in                    (rec30_in),
        .adc30_in                    (adc30_in),
        .free60_in                   (free60_in),
        .free7p5_in                  (free7p5_in),
        .rec7p5_in                   (rec7p5_in),
        .pll25_in                    (pll25_in),
        .free2p5_in                  (free2p5_in),
        .rec2p5_in                   (rec2p5_in),
        .mode_dependent_ref_clock_in (mode_dependent_ref_clock_in),
        .rmii_rx50_in                (rmii_rx50_in),
        .rmii_tx50_in                (rmii_tx50_in),
        .mii_rx_clk_in               (mii_rx_clk_in),
        .rgmii_align_in              (rgmii_align_in),
        .rgmii_shift_in              (rgmii_shift_in),
        .clk_sel_out                 (gp_clk)
    ); // [R2]

    // clock-output clock: full four-bit field
    gcpm_clk_select u_co_clk (
        .src_in                      (co_src),
        .link_master_in              (link_master_in),
        .crystal_input_clock_in      (crystal_input_clock_in),
        .free30_in                   (free30_in),
        .rec30_in                    (rec30_in),
        .adc30_in                    (adc30_in),
        .free60_in                   (free60_in),
        .free7p5_in                  (free7p5_in),
        .rec7p5_in                   (rec7p5_in),
        .pll25_in                    (pll25_in),
        .free2p5_in                  (free2p5_in),
        .rec2p5_in                   (rec2p5_in),
        .mode_dependent_ref_clock_in (mode_dependent_ref_clock_in),
        .rmii_rx50_in                (rmii_rx50_in),
        .rmii_tx50_in                (rmii_tx50_in),
        .mii_rx_clk_in               (mii_rx_clk_in),
        .rgmii_align_in              (rgmii_align_in),
        .rgmii_shift_in              (rgmii_shift_in),
        .clk_sel_out                 (co_clk)
    ); // [R5]

    // strap capture
    gcpm_strap_capture u_strap (
        .clock_in      (clock_in),
        .nrst_in       (nrst_in),
        .ce_in         (ce_in),
        .strap_pins_in (strap_pins_in),
        .strap_out     (strap_vec)
    );

    // divide by two: toggles on each sampled rise of the selected clock.
    // sources are sampled at 50 MHz, so only slow clocks survive faithfully;
    // a true clock-tree divider belongs in the pad ring.
    reg co_clk_q_ff;
    always @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            co_clk_q_ff <= 1'b0;
            div_ff      <= 1'b0;
        end else if (ce_in) begin
            co_clk_q_ff <= co_clk;
            if (co_clk && !co_clk_q_ff) begin
                div_ff <= ~div_ff; // [R7]
            end
        end
    end

    // divide then invert, each optional
    assign co_shaped = (pin_sel_ff[`GCPM_CO_DIV_BIT] ? div_ff : co_clk)
                       ^ pin_sel_ff[`GCPM_CO_INV_BIT]; // [R7] [R8]

    // pin output selection
    always @* begin
        nxt_gpio   = pin_mux_f(gp_sel, led1_ind_in, gp_clk, irq_in);       // [R1]
        nxt_clkout = pin_mux_f(co_sel, led1_ind_in, co_shaped, irq_in);    // [R4]
    end

    // wishbone decode: word index is address bits above the byte lanes
    assign wb_req    = wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_err_out;
    assign hit_sel   = (wb_adr_in[13:2] == `GCPM_IDX_PIN_SEL);
    assign hit_strap = (wb_adr_in[13:2] == `GCPM_IDX_STRAP_LO);

    // register write and read mux
    always @* begin
        nxt_pin_sel = pin_sel_ff;
        nxt_rdata   = 32'h00000000;
        nxt_ack     = 1'b0;
        nxt_err     = 1'b0;
        if (wb_req) begin
            if (hit_sel) begin
                nxt_ack   = 1'b1;
                nxt_rdata = {16'h0000, pin_sel_ff};
                if (wb_we_in) begin
                    if (wb_sel_in[0]) begin
                        nxt_pin_sel[7:0] = wb_dat_in[7:0];
                    end
                    if (wb_sel_in[1]) begin
                        nxt_pin_sel[15:8] = wb_dat_in[15:8];
                    end
                end
            end else if (hit_strap) begin
                nxt_ack   = 1'b1;                   // writes acknowledged, dropped [R11]
                nxt_rdata = {16'h0000, strap_vec};  // [R10]
            end else begin
                nxt_err = 1'b1; // unmapped address
            end
        end
    end

    // registers and registered outputs
    always @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pin_sel_ff        <= `GCPM_PIN_SEL_RESET;
            wb_dat_out        <= 32'h00000000;
            wb_ack_out        <= 1'b0;
            wb_err_out        <= 1'b0;
            gpio_pin_out      <= 1'b0;
            clkout_pin_out    <= 1'b0;
            led2_drive_en_out <= 1'b1;
            led2_led_out      <= 1'b0;
            tx_error_out      <= 1'b0;
        end else if (ce_in) begin
            pin_sel_ff     <= nxt_pin_sel;
            wb_dat_out     <= nxt_rdata;
            wb_ack_out     <= nxt_ack;
            wb_err_out     <= nxt_err;
            gpio_pin_out   <= nxt_gpio;
            clkout_pin_out <= nxt_clkout;
            // led2 becomes an input carrying transmit error when enabled
            led2_drive_en_out <= ~pin_sel_ff[`GCPM_TXER_BIT];                     // [R9]
            led2_led_out      <= led2_ind_in;
            tx_error_out      <= pin_sel_ff[`GCPM_TXER_BIT] ? led2_pin_in : 1'b0; // [R9]
        end
    end

endmodule

/* File: verif/gcpm_pin_mux_props.sv */
// concurrent checks on the pin multiplexer ports
`timescale 1ns/1ps
`include "gcpm_defines.vh"
module gcpm_props (
    // clock, reset, enable
    input wire        clock_in,
    input wire        nrst_in,
    input wire        ce_in,
    // wishbone
    input wire        wb_cyc_in,
    input wire        wb_stb_in,
    input wire        wb_we_in,
    input wire [13:0] wb_adr_in,
    input wire [3:0]  wb_sel_in,
    input wire [31:0] wb_dat_in,
    input wire [31:0] wb_dat_out,
    input wire        wb_ack_out,
    input wire        wb_err_out,
    // sources
    input wire        led1_ind_in,
    input wire        irq_in,
    input wire        led2_pin_in,
    input wire        link_master_in,
    input wire        crystal_input_clock_in,
    input wire        free30_in,
    input wire        rec30_in,
    input wire        mode_dependent_ref_clock_in,
    // pins
    input wire        gpio_pin_out,
    input wire        clkout_pin_out,
    input wire        led2_drive_en_out,
    input wire        tx_error_out
);
    wire        take = wb_cyc_in & wb_stb_in & ~wb_ack_out & ~wb_err_out & ce_in;
    wire [11:0] idx  = wb_adr_in[13:2];
    reg  [15:0] cfg_ff;
    reg         run_ff;
    // shadow of the select register; run_ff hides the first edge after reset
    always @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cfg_ff <= 16'h0000;
            run_ff <= 1'b0;
        end else begin
            run_ff <= ce_in;
            if (take & wb_we_in & (idx == `GCPM_IDX_PIN_SEL)) begin
                if (wb_sel_in[0]) cfg_ff[7:0] <= wb_dat_in[7:0];
                if (wb_sel_in[1]) cfg_ff[15:8] <= wb_dat_in[15:8];
            end
        end
    end
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!nrst_in);
    a_gpio_led: assert property (
        run_ff && $past(cfg_ff[12:10]) == 3'h0 |-> gpio_pin_out == $past(led1_ind_in))
        else $error("gpio pin not led1 indication");
    a_gpio_irq: assert property (
        run_ff && $past(cfg_ff[12:10]) == 3'h2 |-> gpio_pin_out == $past(irq_in))
        else $error("gpio pin not interrupt");
    a_gpio_const: assert property (
        run_ff && $past(cfg_ff[12:10]) > 3'h2 |-> gpio_pin_out == ($past(cfg_ff[12:10]) == 3'h7))
        else $error("gpio pin constant wrong");
    a_gpio_xtal: assert property (
        run_ff && $past(cfg_ff[15:10]) == 6'h01 |-> gpio_pin_out == $past(crystal_input_clock_in))
        else $error("gpio pin not crystal clock");
    a_gpio_line30: assert property (
        run_ff && $past(cfg_ff[15:10]) == 6'h09 |-> gpio_pin_out ==
        ($past(link_master_in) ? $past(free30_in) : $past(rec30_in)))
        else $error("gpio pin line clock wrong");
    a_co_invert: assert property (
        run_ff && $past(cfg_ff[2:0]) == 3'h1 && $past(cfg_ff[8:4]) == 5'h00 |->
        clkout_pin_out == ($past(crystal_input_clock_in) ^ $past(cfg_ff[3])))
        else $error("clock-out inversion wrong");
    a_co_ref: assert property (
        run_ff && $past(cfg_ff[2:0]) == 3'h1 && $past(cfg_ff[8:4]) == 5'h08 |->
        clkout_pin_out == ($past(mode_dependent_ref_clock_in) ^ $past(cfg_ff[3])))
        else $error("clock-out reference wrong");
    a_txer_pin: assert property (
        run_ff |-> led2_drive_en_out == !$past(cfg_ff[9]) &&
        tx_error_out == ($past(cfg_ff[9]) & $past(led2_pin_in)))
        else $error("tx error pin wrong");
    a_ack_pulse: assert property (
        take |=> (wb_ack_out ^ wb_err_out) ##1 !(wb_ack_out | wb_err_out))
        else $error("bus answer not one pulse");
    a_err_unmap: assert property (
        take && idx != `GCPM_IDX_PIN_SEL && idx != `GCPM_IDX_STRAP_LO |=> wb_err_out)
        else $error("unmapped access not refused");
    a_rd_upper: assert property (
        wb_ack_out |-> wb_dat_out[31:16] == 16'h0000 && $past(take))
        else $error("read data upper half or ack wrong");
    cover property (run_ff && $past(cfg_ff[8]) && $past(cfg_ff[2:0]) == 3'h1);
    cover property (wb_err_out);
    cover property (run_ff && tx_error_out);
endmodule
bind gcpm_pin_mux gcpm_props u_props (
    .clock_in(clock_in), .nrst_in(nrst_in), .ce_in(ce_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in),
    .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
    .wb_err_out(wb_err_out), .led1_ind_in(led1_ind_in), .irq_in(irq_in),
    .led2_pin_in(led2_pin_in), .link_master_in(link_master_in),
    .crystal_input_clock_in(crystal_input_clock_in), .free30_in(free30_in),
    .rec30_in(rec30_in), .mode_dependent_ref_clock_in(mode_dependent_ref_clock_in),
    .gpio_pin_out(gpio_pin_out), .clkout_pin_out(clkout_pin_out),
    .led2_drive_en_out(led2_drive_en_out), .tx_error_out(tx_error_out));

/* File: verif/testbench.sv */
// self-checking bench for the pin multiplexer
`timescale 1ns/1ps
`include "gcpm_defines.vh"
module testbench;
    reg         clock_in;
    reg         nrst_in;
    reg         cyc, stb, we, led1_ind, led2_ind, irq, led2_pin, master, e, p, ce;
    reg  [3:0]  sel;
    reg  [13:0] adr;
    reg  [31:0] wdat, q;
    reg  [15:0] clk_v;
    reg  [9:0]  straps;
    wire [31:0] rdat;
    wire        ack, err, gpio, clkout, drv_en, led_out, txerr;
    integer     bad_count, check_count, i, m, k, b;
    // clock sources travel in one vector, bit order of the source table below
    gcpm_pin_mux uut (.clock_in(clock_in), .nrst_in(nrst_in), .ce_in(ce),
        .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
        .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .wb_err_out(err),
        .led1_ind_in(led1_ind), .led2_ind_in(led2_ind), .irq_in(irq), .led2_pin_in(led2_pin),
        .link_master_in(master), .crystal_input_clock_in(clk_v[0]), .free30_in(clk_v[1]),
        .rec30_in(clk_v[2]), .adc30_in(clk_v[3]), .free60_in(clk_v[4]),
        .free7p5_in(clk_v[5]), .rec7p5_in(clk_v[6]), .pll25_in(clk_v[7]),
        .free2p5_in(clk_v[8]), .rec2p5_in(clk_v[9]), .mode_dependent_ref_clock_in(clk_v[10]),
        .rmii_rx50_in(clk_v[11]), .rmii_tx50_in(clk_v[12]), .mii_rx_clk_in(clk_v[13]),
        .rgmii_align_in(clk_v[14]), .rgmii_shift_in(clk_v[15]), .strap_pins_in(straps),
        .gpio_pin_out(gpio), .clkout_pin_out(clkout), .led2_drive_en_out(drv_en),
        .led2_led_out(led_out), .tx_error_out(txerr));
    // which source vector bit a clock code should reach
    function integer src_bit(input integer c, input integer lm);
        case (c)
            0: src_bit = 0;
            1: src_bit = lm ? 1 : 2;
            2: src_bit = 3;
            3: src_bit = 4;
            4: src_bit = lm ? 5 : 6;
            5: src_bit = 7;
            6: src_bit = lm ? 8 : 9;
            default: src_bit = c + 2;
        endcase
    endfunction
    task report_and_stop;
        begin
            if (bad_count == 0 && check_count > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("[FAIL] %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // one classic cycle; a slave that never answers is left to the watchdog
    task wb(input w, input [13:0] a, input [15:0] d);
        begin
            @(posedge clock_in);
            cyc <= 1'b1;
            stb <= 1'b1;
            we <= w;
            adr <= a;
            wdat <= {16'h0000, d};
            @(posedge clock_in);
            while (ack !== 1'b1 && err !== 1'b1) begin
                @(posedge clock_in);
            end
            q = rdat;
            e = err;
            cyc <= 1'b0;
            stb <= 1'b0;
        end
    endtask
    initial begin
        clock_in = 1'b0;
        forever #10 clock_in = ~clock_in;
    end
    initial begin
        #400000;
        bad_count = bad_count + 1;
        report_and_stop;
    end
    initial begin
        {bad_count, check_count} = 0;
        {nrst_in, cyc, stb, we, led1_ind, led2_ind, irq, led2_pin, master, adr, wdat, clk_v} = 0;
        ce = 1'b1;
        sel = 4'h3;
        straps = 10'h2A5;
        repeat (6) @(posedge clock_in);
        nrst_in <= 1'b1;
        // reset values, strap capture, ignored strap write, unmapped place
        wb(0, 14'h118C, 0); chk(q, 0);
        wb(0, 14'h119C, 0); chk(q, 32'h0000_02A5);
        straps <= 10'h15A;
        wb(1, 14'h119C, 16'hFFFF);
        wb(0, 14'h119C, 0); chk(q, 32'h0000_02A5);
        wb(0, 14'h1190, 0); chk(e, 1);
        wb(1, 14'h118C, 16'h1234);
        wb(0, 14'h118C, 0); chk(q, 32'h0000_1234);
        // upper byte lane alone leaves the low byte untouched
        sel <= 4'h2;
        wb(1, 14'h118C, 16'hABCD);
        sel <= 4'h3;
        wb(0, 14'h118C, 0); chk(q, 32'h0000_AB34);
        // second reset recaptures straps and clears the select register
        @(posedge clock_in);
        nrst_in <= 1'b0;
        @(posedge clock_in);
        nrst_in <= 1'b1;
        wb(0, 14'h119C, 0); chk(q, 32'h0000_015A);
        wb(0, 14'h118C, 0); chk(q, 0);
        // every select code on both pins, two input patterns
        for (m = 0; m < 2; m = m + 1) for (i = 0; i < 8; i = i + 1) begin
            led1_ind <= m;
            led2_ind <= !m;
            irq <= !m;
            clk_v <= m;
            wb(1, 14'h118C, {3'h0, i[2:0], 7'h00, i[2:0]});
            k = (i == 7) | ((i < 2) & m) | ((i == 2) & !m);
            repeat (2) @(posedge clock_in);
            chk({gpio, clkout}, {2{k[0]}});
        end
        // every clock code, master and slave, selected line high then low
        for (i = 0; i < 14; i = i + 1) for (m = 0; m < 2; m = m + 1) if (i != 7) begin
            master <= m;
            b = src_bit(i, m);
            wb(1, 14'h118C, {i[2:0], (i < 7) ? 3'h1 : 3'h6, 2'b00, i[3:0], 4'h1});
            for (k = 0; k < 2; k = k + 1) begin
                clk_v <= (16'h0001 << b) ^ {16{k[0]}};
                repeat (3) @(posedge clock_in);
                chk(clkout, !k);
                chk(gpio, (i < 7) && !k);
            end
        end
        // inversion of the clock-out path
        wb(1, 14'h118C, 16'h0009);
        clk_v <= 16'h0001;
        repeat (3) @(posedge clock_in);
        chk(clkout, 0);
        // toggle count over 16 edges: halved when divide is on
        for (k = 0; k < 2; k = k + 1) begin
            wb(1, 14'h118C, k ? 16'h0101 : 16'h0001);
            repeat (4) @(posedge clock_in) clk_v <= ~clk_v;
            b = 0;
            p = clkout;
            for (i = 0; i < 16; i = i + 1) begin
                @(posedge clock_in);
                clk_v <= ~clk_v;
                if (clkout !== p) b = b + 1;
                p = clkout;
            end
            chk(b, k ? 8 : 16);
        end
        // second led pin as transmit-error input and back
        led2_ind <= 1'b1;
        wb(1, 14'h118C, 16'h0200);
        for (k = 0; k < 2; k = k + 1) begin
            led2_pin <= !k;
            repeat (3) @(posedge clock_in);
            chk({drv_en, txerr}, {1'b0, !k[0]});
        end
        wb(1, 14'h118C, 16'h0000);
        led2_pin <= 1'b1;
        repeat (3) @(posedge clock_in);
        chk({drv_en, txerr, led_out}, 3'b101);
        // clock enable low freezes the pins, high lets them follow again
        ce <= 1'b0;
        led1_ind <= 1'b0;
        repeat (3) @(posedge clock_in);
        chk(gpio, 1);
        ce <= 1'b1;
        repeat (3) @(posedge clock_in);
        chk(gpio, 0);
        report_and_stop;
    end
endmodule
